// ===== hdl/pmc_pkg.sv
// package: register map, field positions, reset values and timing of the power mode control block
package pmc_pkg;
    localparam logic [31:0] PMC_ADDR_POWER_MODE_CONTROL = 32'hE01FC0C0;
    localparam int          PMC_BIT_IDLE                = 0;
    localparam int          PMC_BIT_POWERDOWN           = 1;
    localparam int          PMC_BIT_BO_SLEEP_PD         = 2;
    localparam int          PMC_BIT_BO_GLOBAL_OFF       = 3;
    localparam int          PMC_BIT_BO_RESET_OFF        = 4;
    localparam int          PMC_CTRL_WIDTH              = 5;
    localparam logic [7:0]  PMC_RESET_VALUE             = 8'h00;
    // wakeup timer: oscillator settle time in ns, converted to clk cycles
    localparam int          PMC_CLK_PERIOD_NS           = 10;
    localparam int          PMC_OSC_SETTLE_NS           = 20480;
    localparam int          PMC_OSC_SETTLE_CYCLES       = (PMC_OSC_SETTLE_NS + PMC_CLK_PERIOD_NS - 1) / PMC_CLK_PERIOD_NS;
    typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_POWERDOWN, PMC_WAKEUP} pmc_state_t;
endpackage

// ===== hdl/pmc_top.sv
// power mode control register with idle / power-down sequencing and brown-out controls
// Functional notes
// - idle bit stops cpu clock, peripherals run
// - any enabled interrupt ends idle
// - both bits set enters power-down
// - power-down stops oscillator and all clocks
// - external interrupt restarts oscillator, clears power-down bit
// - cpu held until wakeup timer reports stable
// - power-down accepted anytime without usb wake
// - usb wake plus clock-needed blocks power-down
// - brown-out active in power-down, reset wakes
// - brown-out sleeps in power-down, no wakeup
// - global off bit disables brown-out entirely
// - reset enabled, first-stage interrupt unaffected
// - reset-off bit masks second-stage chip reset
// - resume at instruction boundary, nothing lost
// - state, memories and pins held in power-down
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module pmc_top
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYCLES = PMC_OSC_SETTLE_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        irq_pending,
    input  wire logic        ext_wake_irq,
    input  wire logic        cpu_at_boundary,
    input  wire logic        usb_wake_enable,
    input  wire logic        usb_need_clock,
    input  wire logic        bo_stage1_detect,
    input  wire logic        bo_stage2_detect,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             osc_en,
    output logic             hold_state,
    output logic             bo_enable,
    output logic             bo_irq,
    output logic             bo_chip_reset,
    output logic             in_idle,
    output logic             in_powerdown
);
    initial
    begin
        if (SETTLE_CYCLES < 1)
            $error("pmc_top: SETTLE_CYCLES must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register
    logic [PMC_CTRL_WIDTH-1:0] ctrl;
    pmc_state_t                state;
    logic                      wake_start;
    logic                      wake_done;
    logic                      hit;
    logic                      pd_allowed;
    logic                      hw_clear_pd;
    logic                      bo_active;

    assign hit        = (reg_addr == PMC_ADDR_POWER_MODE_CONTROL);
    // a power-down write is refused only when usb wake is enabled and usb needs its clock
    assign pd_allowed = !usb_wake_enable || !usb_need_clock;
    assign hw_clear_pd = (state == PMC_POWERDOWN) && ext_wake_irq;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= PMC_RESET_VALUE[PMC_CTRL_WIDTH-1:0];
        else
        begin
            if (reg_wr && hit)
            begin
                // bits 7:5 are not stored; software is expected to write zero
                ctrl[PMC_BIT_IDLE]          <= reg_wdata[PMC_BIT_IDLE];
                ctrl[PMC_BIT_POWERDOWN]     <= reg_wdata[PMC_BIT_POWERDOWN] && pd_allowed;
                ctrl[PMC_BIT_BO_SLEEP_PD]   <= reg_wdata[PMC_BIT_BO_SLEEP_PD];
                ctrl[PMC_BIT_BO_GLOBAL_OFF] <= reg_wdata[PMC_BIT_BO_GLOBAL_OFF];
                ctrl[PMC_BIT_BO_RESET_OFF]  <= reg_wdata[PMC_BIT_BO_RESET_OFF];
            end
            // hardware clears on wakeup; a write in the same cycle is overridden by the wake
            if (hw_clear_pd)
                ctrl[PMC_BIT_POWERDOWN] <= 1'b0;
            if ((state == PMC_IDLE) && irq_pending)
                ctrl[PMC_BIT_IDLE] <= 1'b0;
            if ((state == PMC_POWERDOWN) && ext_wake_irq)
                ctrl[PMC_BIT_IDLE] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd && hit)
            reg_rdata <= {27'h0000000, ctrl};
        else
            reg_rdata <= 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= PMC_RUN;
        else
        begin
            case (state)
                PMC_RUN:
                begin
                    // entry waits for the cpu to reach an instruction boundary
                    if (cpu_at_boundary && ctrl[PMC_BIT_POWERDOWN])
                        state <= PMC_POWERDOWN;
                    else if (cpu_at_boundary && ctrl[PMC_BIT_IDLE])
                        state <= PMC_IDLE;
                end
                PMC_IDLE:
                begin
                    if (ctrl[PMC_BIT_POWERDOWN])
                        state <= PMC_POWERDOWN;
                    else if (irq_pending)
                        state <= PMC_RUN;
                end
                PMC_POWERDOWN:
                begin
                    if (ext_wake_irq)
                        state <= PMC_WAKEUP;
                end
                PMC_WAKEUP:
                begin
                    if (wake_done)
                        state <= PMC_RUN;
                end
                default:
                    state <= PMC_RUN;
            endcase
        end
    end

    assign wake_start = hw_clear_pd;

    pmc_wake_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_wake_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .start (wake_start),
        .done  (wake_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hold outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_en        <= 1'b1;
            hold_state    <= 1'b0;
            in_idle       <= 1'b0;
            in_powerdown  <= 1'b0;
        end
        else
        begin
            // cpu clock stays off through the settle wait so no instruction runs early
            cpu_clk_en    <= (state == PMC_RUN);
            periph_clk_en <= (state == PMC_RUN) || (state == PMC_IDLE);
            osc_en        <= (state != PMC_POWERDOWN);
            hold_state    <= (state == PMC_POWERDOWN) || (state == PMC_WAKEUP);
            in_idle       <= (state == PMC_IDLE);
            in_powerdown  <= (state == PMC_POWERDOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // brown-out control
    assign bo_active = !ctrl[PMC_BIT_BO_GLOBAL_OFF] &&
                       !(ctrl[PMC_BIT_BO_SLEEP_PD] && (state == PMC_POWERDOWN));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bo_enable     <= 1'b0;
            bo_irq        <= 1'b0;
            bo_chip_reset <= 1'b0;
        end
        else
        begin
            bo_enable     <= bo_active;
            bo_irq        <= bo_active && bo_stage1_detect;
            // chip reset is also the power-down wake path when the detector stays awake
            bo_chip_reset <= bo_active && bo_stage2_detect && !ctrl[PMC_BIT_BO_RESET_OFF];
        end
    end
endmodule

// ===== hdl/pmc_wake_timer.sv
// wakeup timer: counts oscillator settle cycles after restart
`timescale 1ns/1ns
module pmc_wake_timer
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYCLES = PMC_OSC_SETTLE_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      done
);
    initial
    begin
        if (SETTLE_CYCLES < 1)
            $error("pmc_wake_timer: SETTLE_CYCLES must be at least 1");
    end

    logic [31:0] count;
    logic        running;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count   <= 32'h00000000;
            running <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                count   <= 32'h00000000;
                running <= 1'b1;
            end
            else if (running)
            begin
                if (count == 32'(SETTLE_CYCLES - 1))
                begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                else
                    count <= count + 32'h00000001;
            end
        end
    end
endmodule

// ===== tb/pmc_props.sv
// checker: port-level assertions for the power mode control block
`timescale 1ns/1ns
module pmc_chk
    import pmc_pkg::*;
#(
    parameter int SETTLE_CYCLES = 4
)
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq_pending,
    input wire logic        ext_wake_irq,
    input wire logic        cpu_at_boundary,
    input wire logic        usb_wake_enable,
    input wire logic        usb_need_clock,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        osc_en,
    input wire logic        in_idle,
    input wire logic        in_powerdown
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // entry only judged when no wake source can cut it short
    wire hit  = reg_addr == PMC_ADDR_POWER_MODE_CONTROL;
    wire calm = cpu_at_boundary && !irq_pending && !ext_wake_irq;
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_zero; !(reg_rd && hit) |=> reg_rdata == 32'h0; endproperty
    property p_idle_in; reg_wr && hit && reg_wdata[1:0] == 2'h1 && cpu_clk_en ##1 calm [*2] |=> in_idle && !cpu_clk_en && periph_clk_en; endproperty
    property p_pd_in; reg_wr && hit && reg_wdata[1] && !usb_wake_enable && cpu_clk_en ##1 calm [*2] |=> in_powerdown && !in_idle; endproperty
    property p_usb_blk; reg_wr && hit && reg_wdata[1:0] == 2'h2 && usb_wake_enable && usb_need_clock |=> !in_powerdown [*4]; endproperty
    property p_pd_clk; $rose(in_powerdown) |-> !osc_en && !cpu_clk_en && !periph_clk_en; endproperty
    property p_wake; in_powerdown && ext_wake_irq |-> ##[1:3] osc_en; endproperty
    property p_settle; $rose(osc_en) |-> !cpu_clk_en [*4]; endproperty
    property p_idle_out; in_idle && irq_pending |-> ##[1:3] cpu_clk_en; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    a_idle_in: assert property (p_idle_in) else $error("idle not entered");
    a_pd_in: assert property (p_pd_in) else $error("power-down not entered");
    a_usb_blk: assert property (p_usb_blk) else $error("power-down not blocked");
    a_pd_clk: assert property (p_pd_clk) else $error("clocks run in power-down");
    a_wake: assert property (p_wake) else $error("oscillator not restarted");
    a_settle: assert property (p_settle) else $error("cpu released early");
    a_idle_out: assert property (p_idle_out) else $error("idle not left");
    c_idle: cover property (in_idle && irq_pending);
    c_wake: cover property (in_powerdown && ext_wake_irq);
    c_block: cover property (reg_wr && hit && usb_wake_enable && usb_need_clock);
endmodule
bind pmc_top pmc_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_pmc_chk (.*);

// ===== tb/pmc_tb_top.sv
// testbench: registers, idle, power-down wake, usb gating and brown-out controls
`timescale 1ns/1ns
module pmc_tb_top;
    import pmc_pkg::*;
    localparam logic [31:0] ra = PMC_ADDR_POWER_MODE_CONTROL;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        irq_pending = 1'b0;
    logic        ext_wake_irq = 1'b0;
    logic        cpu_at_boundary = 1'b1;
    logic        usb_wake_enable = 1'b0;
    logic        usb_need_clock = 1'b0;
    logic        bo_stage1_detect = 1'b0;
    logic        bo_stage2_detect = 1'b0;
    logic [31:0] reg_rdata, v;
    logic        cpu_clk_en, periph_clk_en, osc_en, hold_state, bo_enable, bo_irq, bo_chip_reset, in_idle, in_powerdown;
    logic [4:0]  c;
    logic [31:0] pd_data [3] = '{32'h6, 32'h2, 32'h3};
    int          fail_count = 0;
    int          checks_done = 0;
    int          seed = 32'h747CA05E;
    always #5 clk = ~clk;
    // short settle count keeps the wake walk brief
    pmc_top #(.SETTLE_CYCLES(4)) i_pmc_top (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ra;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [2:0] bo_exp(input logic [4:0] r, input logic s1, input logic s2);
        return {!r[3], s1 && !r[3], s2 && !r[3] && !r[4]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        rd(ra);
        chk("reset value", v, {24'h0, PMC_RESET_VALUE});
        chk("run clocks", {cpu_clk_en, periph_clk_en, osc_en, in_idle, in_powerdown}, 5'h1C);
        rd(ra + 32'h4);
        chk("unmapped", v, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            c = (i == 0) ? 5'h10 : 5'($random(seed)) & 5'h1C;
            wr({27'h0, c});
            rd(ra);
            chk("readback", v, {27'h0, c});
            bo_stage1_detect <= (i == 0) | 1'($random(seed));
            bo_stage2_detect <= (i == 0) | 1'($random(seed));
            cyc(3);
            chk("brownout", {bo_enable, bo_irq, bo_chip_reset}, bo_exp(c, bo_stage1_detect, bo_stage2_detect));
        end
        bo_stage1_detect <= 1'b0;
        bo_stage2_detect <= 1'b0;
        $display("test brownout done");
        wr(32'h1);
        cyc(3);
        chk("idle", {cpu_clk_en, periph_clk_en, osc_en, in_idle}, 4'h7);
        irq_pending <= 1'b1;
        cyc(1);
        irq_pending <= 1'b0;
        cyc(3);
        chk("idle wake", {cpu_clk_en, in_idle}, 2'h2);
        $display("test idle done");
        usb_wake_enable <= 1'b1;
        usb_need_clock <= 1'b1;
        wr(32'h2);
        cyc(4);
        chk("usb block", in_powerdown, 1'b0);
        rd(ra);
        chk("usb block reg", v[1], 1'b0);
        usb_need_clock <= 1'b0;
        $display("test usb block done");
        for (int k = 0; k < 3; k++)
        begin
            usb_wake_enable <= (k == 1);
            wr(pd_data[k]);
            cyc(3);
            chk("powerdown", {cpu_clk_en, periph_clk_en, osc_en, in_idle, in_powerdown, hold_state, bo_enable}, {6'h3, k != 0});
            ext_wake_irq <= 1'b1;
            cyc(1);
            ext_wake_irq <= 1'b0;
            cyc(2);
            chk("settling", {osc_en, cpu_clk_en, hold_state}, 3'h5);
            cyc(12);
            chk("woken", {osc_en, in_powerdown}, 2'h2);
            rd(ra);
            chk("pd cleared", v[1], 1'b0);
            // the wake clears the idle bit too, so no idle parks the cpu; this interrupt finds it running
            irq_pending <= 1'b1;
            cyc(1);
            irq_pending <= 1'b0;
            cyc(4);
            chk("resumed", cpu_clk_en, 1'b1);
            $display("test powerdown %0d done", k);
        end
        final_report();
    end
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule
